// file: common/scale_pkg.sv
// constants shared by the scale frame receiver files
package scale_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    // serial character: 7 data bits, even parity, two stop bits
    localparam int DATA_BITS = 7;
    localparam int FRAME_BITS = 10;
    localparam logic [3:0] PARITY_POS = 4'h7;
    localparam logic [3:0] STOP1_POS = 4'h8;
    localparam logic [3:0] LAST_POS = 4'h9;
    // bit rates in baud for each rate code 0..4, and the bit periods in clock cycles derived from them
    localparam int BAUD_0 = 1200;
    localparam int BAUD_1 = 2400;
    localparam int BAUD_2 = 4800;
    localparam int BAUD_3 = 9600;
    localparam int BAUD_4 = 19200;
    localparam logic [13:0] DIV_0 = 14'(CLK_HZ / BAUD_0);
    localparam logic [13:0] DIV_1 = 14'(CLK_HZ / BAUD_1);
    localparam logic [13:0] DIV_2 = 14'(CLK_HZ / BAUD_2);
    localparam logic [13:0] DIV_3 = 14'(CLK_HZ / BAUD_3);
    localparam logic [13:0] DIV_4 = 14'(CLK_HZ / BAUD_4);
    localparam logic [2:0] BAUD_CODE_RESET = 3'h3;
    // message layout, positions counted from the start character
    localparam logic [6:0] CHAR_STX = 7'h02;
    localparam logic [6:0] CHAR_CR = 7'h0d;
    localparam logic [4:0] POS_STAT_FIRST = 5'h01;
    localparam logic [4:0] POS_STAT_LAST = 5'h03;
    localparam logic [4:0] POS_WGT_FIRST = 5'h04;
    localparam logic [4:0] POS_WGT_LAST = 5'h09;
    localparam logic [4:0] POS_TARE_FIRST = 5'h0a;
    localparam logic [4:0] POS_TARE_LAST = 5'h0f;
    localparam logic [4:0] POS_CR = 5'h10;
    localparam logic [4:0] POS_CKSUM = 5'h11;
    // register numbers
    localparam logic [6:0] REG_LINK = 7'h04;
    localparam logic [6:0] REG_LIVE_STAT_A = 7'h0e;
    localparam logic [6:0] REG_LIVE_STAT_C = 7'h10;
    localparam logic [6:0] REG_WR_FIRST = 7'h14;
    localparam logic [6:0] REG_CONFIG = 7'h14;
    localparam logic [6:0] REG_BAUD = 7'h15;
    localparam logic [6:0] REG_WR_LAST = 7'h26;
    localparam logic [6:0] REG_ERR_COUNT = 7'h28;
    localparam logic [6:0] REG_REQUEST = 7'h40;
    localparam logic [6:0] REG_MSG_COUNT = 7'h41;
    localparam logic [6:0] REG_STAT_A = 7'h42;
    localparam logic [6:0] REG_STAT_B = 7'h43;
    localparam logic [6:0] REG_STAT_C = 7'h44;
    localparam logic [6:0] REG_WGT_HI = 7'h45;
    localparam logic [6:0] REG_WGT_LO = 7'h46;
    localparam logic [6:0] REG_TARE_HI = 7'h47;
    localparam logic [6:0] REG_TARE_LO = 7'h48;
    localparam int WR_REGS = 19;
    localparam logic [15:0] CONFIG_RESET = 16'h0001;
    // buffer between character receiver and framer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b11
    } rx_state_t;
    typedef enum logic [1:0] {
        FR_HUNT = 2'b00,
        FR_BODY = 2'b01,
        FR_COMMIT = 2'b11
    } frame_state_t;
endpackage

// file: design/char_fifo.sv
// synchronous valid/ready fifo between character receiver and framer
`timescale 1ns/10ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rptr_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: design/scale_frame_rx.sv
// scale indicator serial message receiver with backplane register port
//
// Function
// - frame starts at STX, earlier characters ignored
// - three status bytes captured in arrival order
// - six characters collected as indicated weight
// - six characters collected as tare weight
// - carriage return required after tare field
// - one checksum byte ends the frame
// - checksum negates sum of low seven bits
// - 32-bit pair: lower register holds upper half
// - register space numbered zero through seventy-two
// - 7 bits, even parity, start, two stops
// - bit rate selectable 1200 to 19200 baud
// - only registers 20-38 writable, others bus error
`timescale 1ns/10ps
module scale_frame_rx
    import scale_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic serial_in,
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_bus_err,
    output logic frame_ok,
    output logic frame_err
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and host configuration
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic [15:0] wr_mem [WR_REGS];
    logic [15:0] config_reg;
    logic [2:0] baud_code_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    wire addr_writable = (reg_addr >= REG_WR_FIRST) && (reg_addr <= REG_WR_LAST);
    wire addr_mapped = (reg_addr <= REG_TARE_LO);
    wire wr_ok = reg_wr && addr_writable;
    wire wr_bad = reg_wr && !addr_writable;
    wire rd_bad = reg_rd && !addr_mapped;
    wire [4:0] wr_index = 5'(reg_addr - REG_WR_FIRST);

    always_ff @(posedge clock) begin
        if (wr_ok) begin
            wr_mem[wr_index] <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            config_reg <= CONFIG_RESET;
            baud_code_reg <= BAUD_CODE_RESET;
        end else if (wr_ok && reg_addr == REG_CONFIG) begin
            config_reg <= reg_wdata;
        end else if (wr_ok && reg_addr == REG_BAUD) begin
            baud_code_reg <= reg_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit-rate divider
    wire rx_enable = config_reg[0];
    wire [13:0] bit_div = (baud_code_reg == 3'h0) ? DIV_0 :
                          (baud_code_reg == 3'h1) ? DIV_1 :
                          (baud_code_reg == 3'h2) ? DIV_2 :
                          (baud_code_reg == 3'h4) ? DIV_4 : DIV_3;
    rx_state_t rx_state_reg;
    logic [13:0] div_cnt_reg;
    logic [3:0] bit_pos_reg;
    logic [9:0] shift_reg;
    logic char_valid_reg;
    logic [7:0] char_data_reg;
    logic overrun_reg;
    wire fifo_in_ready;
    wire bit_tick = (div_cnt_reg == 14'h0000);
    wire start_seen = (rx_state_reg == RX_IDLE) && !rx_sync_reg && rx_enable;

    always_ff @(posedge clock) begin
        if (srst || start_seen) begin
            div_cnt_reg <= {1'b0, bit_div[13:1]};
        end else if (bit_tick) begin
            div_cnt_reg <= bit_div - 14'h0001;
        end else begin
            div_cnt_reg <= div_cnt_reg - 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // character receiver: start, 7 data, parity, 2 stop, sampled mid-bit
    wire [9:0] shift_next = {rx_sync_reg, shift_reg[9:1]};
    wire par_bad = ^shift_next[7:0];
    wire stop_bad = !shift_next[8] || !shift_next[9];

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_state_reg <= RX_IDLE;
            bit_pos_reg <= 4'h0;
            shift_reg <= '0;
            char_valid_reg <= 1'b0;
            char_data_reg <= 8'h00;
        end else begin
            char_valid_reg <= char_valid_reg && !fifo_in_ready;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (start_seen) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (bit_tick) begin
                        rx_state_reg <= rx_sync_reg ? RX_IDLE : RX_BITS;
                        bit_pos_reg <= 4'h0;
                    end
                end
                RX_BITS: begin
                    if (bit_tick) begin
                        shift_reg <= shift_next;
                        bit_pos_reg <= bit_pos_reg + 4'h1;
                        if (bit_pos_reg == LAST_POS) begin
                            rx_state_reg <= RX_IDLE;
                            char_valid_reg <= 1'b1;
                            char_data_reg <= {par_bad || stop_bad, shift_next[6:0]};
                        end
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // a character still waiting when the next completes is lost and flagged
    always_ff @(posedge clock) begin
        if (srst) begin
            overrun_reg <= 1'b0;
        end else if (char_valid_reg && !fifo_in_ready && rx_state_reg == RX_BITS
                     && bit_tick && bit_pos_reg == LAST_POS) begin
            overrun_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // character buffer
    wire [7:0] ch_data;
    wire ch_valid;
    wire ch_ready;

    char_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .srst(srst),
        .in_data(char_data_reg),
        .in_valid(char_valid_reg),
        .in_ready(fifo_in_ready),
        .out_data(ch_data),
        .out_valid(ch_valid),
        .out_ready(ch_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // framer
    frame_state_t fr_state_reg;
    logic [4:0] pos_reg;
    logic [6:0] sum_reg;
    logic [6:0] stat_tmp [3];
    logic [23:0] wgt_tmp_reg;
    logic [23:0] tare_tmp_reg;
    logic [6:0] live_stat [3];
    logic [23:0] live_wgt_reg;
    logic [23:0] live_tare_reg;
    logic [15:0] msg_count_reg;
    logic [15:0] err_count_reg;
    logic link_ok_reg;
    logic frame_ok_reg;
    logic frame_err_reg;

    // the framer stalls for one cycle while a good frame is committed
    assign ch_ready = (fr_state_reg != FR_COMMIT);
    wire take = ch_valid && ch_ready;
    wire [6:0] ch7 = ch_data[6:0];
    wire ch_bad = ch_data[7];
    wire is_stx = (ch7 == CHAR_STX);
    wire in_stat = (pos_reg >= POS_STAT_FIRST) && (pos_reg <= POS_STAT_LAST);
    wire in_wgt = (pos_reg >= POS_WGT_FIRST) && (pos_reg <= POS_WGT_LAST);
    wire in_tare = (pos_reg >= POS_TARE_FIRST) && (pos_reg <= POS_TARE_LAST);
    wire cr_bad = (pos_reg == POS_CR) && (ch7 != CHAR_CR);
    wire at_cksum = (pos_reg == POS_CKSUM);
    wire [6:0] sum_next = sum_reg + ch7;
    wire cksum_bad = (ch7 != 7'(-sum_reg));
    wire [1:0] stat_idx = 2'(pos_reg - POS_STAT_FIRST);
    // a checksum byte that happens to equal the start code is still the checksum
    wire restart = take && is_stx && !ch_bad && !at_cksum;
    wire body_fail = take && (fr_state_reg == FR_BODY) && !restart
                     && (ch_bad || cr_bad || (at_cksum && cksum_bad));
    wire body_done = take && (fr_state_reg == FR_BODY) && !ch_bad
                     && at_cksum && !cksum_bad;

    always_ff @(posedge clock) begin
        if (srst) begin
            fr_state_reg <= FR_HUNT;
            pos_reg <= 5'h00;
            sum_reg <= 7'h00;
            wgt_tmp_reg <= '0;
            tare_tmp_reg <= '0;
        end else begin
            case (fr_state_reg)
                FR_HUNT: begin
                    if (take && is_stx && !ch_bad) begin
                        fr_state_reg <= FR_BODY;
                        pos_reg <= POS_STAT_FIRST;
                        sum_reg <= ch7;
                    end
                end
                FR_BODY: begin
                    if (restart) begin
                        pos_reg <= POS_STAT_FIRST;
                        sum_reg <= ch7;
                    end else if (body_fail) begin
                        fr_state_reg <= FR_HUNT;
                    end else if (body_done) begin
                        fr_state_reg <= FR_COMMIT;
                    end else if (take) begin
                        pos_reg <= pos_reg + 5'h01;
                        sum_reg <= sum_next;
                        if (in_wgt) begin
                            wgt_tmp_reg <= {wgt_tmp_reg[19:0], ch7[3:0]};
                        end
                        if (in_tare) begin
                            tare_tmp_reg <= {tare_tmp_reg[19:0], ch7[3:0]};
                        end
                    end
                end
                FR_COMMIT: begin
                    fr_state_reg <= FR_HUNT;
                end
                default: begin
                    fr_state_reg <= FR_HUNT;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_stat
            always_ff @(posedge clock) begin
                if (srst) begin
                    stat_tmp[gi] <= 7'h00;
                    live_stat[gi] <= 7'h00;
                end else begin
                    if (take && fr_state_reg == FR_BODY && in_stat && stat_idx == 2'(gi)) begin
                        stat_tmp[gi] <= ch7;
                    end
                    if (fr_state_reg == FR_COMMIT) begin
                        live_stat[gi] <= stat_tmp[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (srst) begin
            live_wgt_reg <= '0;
            live_tare_reg <= '0;
            msg_count_reg <= 16'h0000;
            err_count_reg <= 16'h0000;
            link_ok_reg <= 1'b0;
            frame_ok_reg <= 1'b0;
            frame_err_reg <= 1'b0;
        end else begin
            frame_ok_reg <= (fr_state_reg == FR_COMMIT);
            frame_err_reg <= body_fail;
            if (fr_state_reg == FR_COMMIT) begin
                live_wgt_reg <= wgt_tmp_reg;
                live_tare_reg <= tare_tmp_reg;
                msg_count_reg <= msg_count_reg + 16'h0001;
                link_ok_reg <= 1'b1;
            end else if (body_fail) begin
                err_count_reg <= err_count_reg + 16'h0001;
                link_ok_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // snapshot on request, register read
    logic [6:0] snap_stat [3];
    logic [23:0] snap_wgt_reg;
    logic [23:0] snap_tare_reg;
    logic [15:0] snap_count_reg;
    wire request = reg_rd && (reg_addr == REG_REQUEST);

    always_ff @(posedge clock) begin
        if (srst) begin
            snap_wgt_reg <= '0;
            snap_tare_reg <= '0;
            snap_count_reg <= 16'h0000;
            snap_stat <= '{default: 7'h00};
        end else if (request) begin
            snap_wgt_reg <= live_wgt_reg;
            snap_tare_reg <= live_tare_reg;
            snap_count_reg <= msg_count_reg;
            snap_stat <= live_stat;
        end
    end

    wire [31:0] wgt32 = {8'h00, snap_wgt_reg};
    wire [31:0] tare32 = {8'h00, snap_tare_reg};
    wire [1:0] live_idx = 2'(reg_addr - REG_LIVE_STAT_A);
    wire in_live = (reg_addr >= REG_LIVE_STAT_A) && (reg_addr <= REG_LIVE_STAT_C);
    wire [15:0] rd_mux =
        (reg_addr == REG_LINK) ? {14'h0000, overrun_reg, link_ok_reg} :
        in_live ? {9'h000, live_stat[live_idx]} :
        (reg_addr == REG_CONFIG) ? config_reg :
        (reg_addr == REG_BAUD) ? {13'h0000, baud_code_reg} :
        addr_writable ? wr_mem[wr_index] :
        (reg_addr == REG_ERR_COUNT) ? err_count_reg :
        (reg_addr == REG_MSG_COUNT) ? snap_count_reg :
        (reg_addr == REG_STAT_A) ? {9'h000, snap_stat[0]} :
        (reg_addr == REG_STAT_B) ? {9'h000, snap_stat[1]} :
        (reg_addr == REG_STAT_C) ? {9'h000, snap_stat[2]} :
        (reg_addr == REG_WGT_HI) ? wgt32[31:16] :
        (reg_addr == REG_WGT_LO) ? wgt32[15:0] :
        (reg_addr == REG_TARE_HI) ? tare32[31:16] :
        (reg_addr == REG_TARE_LO) ? tare32[15:0] : 16'h0000;

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_bus_err <= 1'b0;
        end else begin
            reg_ack <= (reg_rd && addr_mapped) || wr_ok;
            reg_bus_err <= wr_bad || rd_bad;
            reg_rdata <= (reg_rd && addr_mapped) ? rd_mux : 16'h0000;
        end
    end

    assign frame_ok = frame_ok_reg;
    assign frame_err = frame_err_reg;
endmodule

// file: dv/scale_frame_rx_checker.sv
// port assertions for the scale frame receiver
`timescale 1ns/10ps
module scale_frame_rx_checker
    import scale_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic serial_in,
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_bus_err,
    input wire logic frame_ok,
    input wire logic frame_err
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire logic wr_in = (reg_addr >= REG_WR_FIRST) && (reg_addr <= REG_WR_LAST);
    wire logic rd_in = reg_addr <= REG_TARE_LO;
    wire logic strobe = reg_rd || reg_wr;
    sequence s_req;
        reg_rd && !reg_wr && reg_addr == REG_REQUEST;
    endsequence
    sequence s_zero_ack;
        reg_ack && !reg_bus_err && reg_rdata == 16'h0000;
    endsequence
    a_wr_refused: assert property (reg_wr && !wr_in |=> reg_bus_err && !reg_ack)
        else $error("write outside writable range not refused");
    a_wr_taken: assert property (reg_wr && !reg_rd && wr_in |=> reg_ack && !reg_bus_err)
        else $error("write inside writable range not acknowledged");
    a_rd_beyond: assert property (reg_rd && !reg_wr && !rd_in |=> reg_bus_err && !reg_ack)
        else $error("read above register space not refused");
    a_rd_inside: assert property (reg_rd && !reg_wr && rd_in |=> reg_ack && !reg_bus_err)
        else $error("read inside register space not acknowledged");
    a_req_reads_zero: assert property (s_req |=> s_zero_ack)
        else $error("update request read did not answer zero");
    a_no_spurious: assert property (!strobe |=> !reg_ack && !reg_bus_err)
        else $error("answer without a request");
    a_rdata_idle: assert property (!reg_ack |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside acknowledge");
    a_frame_single: assert property (frame_ok || frame_err |=> !frame_ok && !frame_err)
        else $error("frame result longer than one cycle");
    a_frame_excl: assert property (!(frame_ok && frame_err))
        else $error("frame both good and discarded");
    a_frame_gap: assert property (frame_ok |=> !frame_ok [*8])
        else $error("good frames too close together");
endmodule
bind scale_frame_rx scale_frame_rx_checker chk (
    .clock(clock),
    .srst(srst),
    .serial_in(serial_in),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_ack(reg_ack),
    .reg_bus_err(reg_bus_err),
    .frame_ok(frame_ok),
    .frame_err(frame_err)
);

// file: dv/scale_tx_model.sv
// behavioural indicator transmitter driving the serial line
`timescale 1ns/10ps
module scale_tx_model (
    input wire logic clock,
    input wire logic [13:0] bit_div,
    output logic line
);
    initial line = 1'b1;
    // start, 7 data lsb first, even parity, two stops; bad_par flips parity
    task automatic send_char(input logic [6:0] c, input logic bad_par);
        logic [10:0] bits;
        int i;
        bits = {2'b11, (^c) ^ bad_par, c, 1'b0};
        @(posedge clock);
        #1;
        for (i = 0; i < 11; i++) begin
            line = bits[i];
            repeat (bit_div) @(posedge clock);
            #1;
        end
    endtask
endmodule

// file: dv/scale_frame_receiver_tb_top.sv
// self-checking bench for the scale frame receiver
`timescale 1ns/10ps
module scale_frame_receiver_tb_top
    import scale_pkg::*;
;
    typedef struct {
        logic wr;
        logic [6:0] addr;
        logic [15:0] wdata;
        logic err;
        logic [15:0] rdata;
    } row_t;
    logic clock, srst, serial_in, reg_rd, reg_wr, reg_ack, reg_bus_err, frame_ok, frame_err;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic ack, err, ok, bad;
    logic [6:0] fr[18];
    row_t rows[14];
    int err_total = 0;
    int n_tests = 0;
    scale_frame_rx dut (.clock(clock), .srst(srst), .serial_in(serial_in), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_bus_err(reg_bus_err), .frame_ok(frame_ok),
        .frame_err(frame_err));
    scale_tx_model tx (.clock(clock), .bit_div(DIV_4), .line(serial_in));
    initial clock = 1'b0;
    always #50 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd = reg_rdata;
        ack = reg_ack;
        err = reg_bus_err;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        access(1'b0, a, 16'h0000);
        chk1("reg_ack", 1'b1, ack);
        chk16("reg_rdata", exp, rd);
    endtask
    task automatic wait_frame();
        int k;
        ok = 1'b0;
        bad = 1'b0;
        for (k = 0; k < 150000 && !ok && !bad; k++) begin
            @(posedge clock);
            #1;
            ok = (frame_ok === 1'b1);
            bad = (frame_err === 1'b1);
        end
        if (!ok && !bad) begin
            err_total++;
            $display("MISMATCH frame_result expected pulse seen none");
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        rows = '{'{1'b0, 7'h14, 16'h0000, 1'b0, 16'h0001}, '{1'b0, 7'h15, 16'h0000, 1'b0, 16'h0003},
            '{1'b1, 7'h15, 16'h0004, 1'b0, 16'h0000}, '{1'b0, 7'h15, 16'h0000, 1'b0, 16'h0004},
            '{1'b1, 7'h26, 16'h5a5a, 1'b0, 16'h0000}, '{1'b0, 7'h26, 16'h0000, 1'b0, 16'h5a5a},
            '{1'b1, 7'h13, 16'h1234, 1'b1, 16'h0000}, '{1'b1, 7'h27, 16'h1234, 1'b1, 16'h0000},
            '{1'b1, 7'h40, 16'h0001, 1'b1, 16'h0000}, '{1'b0, 7'h49, 16'h0000, 1'b1, 16'h0000},
            '{1'b0, 7'h7f, 16'h0000, 1'b1, 16'h0000}, '{1'b0, 7'h04, 16'h0000, 1'b0, 16'h0000},
            '{1'b0, 7'h45, 16'h0000, 1'b0, 16'h0000}, '{1'b0, 7'h00, 16'h0000, 1'b0, 16'h0000}};
        repeat (16) @(posedge clock);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clock);
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].addr, rows[i].wdata);
            chk1("reg_ack", !rows[i].err, ack);
            chk1("reg_bus_err", rows[i].err, err);
            chk16("reg_rdata", rows[i].rdata, rd);
        end
        $display("test register_table done");
        // stx, status a b c, weight 012345, tare 000100, cr, checksum
        fr = '{7'h02, 7'h41, 7'h42, 7'h43, 7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35,
            7'h30, 7'h30, 7'h30, 7'h31, 7'h30, 7'h30, 7'h0d, 7'h00};
        for (int i = 0; i < 17; i++) begin
            fr[17] = fr[17] - fr[i];
        end
        fork
            begin
                tx.send_char(7'h5a, 1'b0);
                foreach (fr[i]) tx.send_char(fr[i], 1'b0);
            end
            wait_frame();
        join
        chk1("frame_ok", 1'b1, ok);
        chk1("frame_err", 1'b0, bad);
        rd_chk(7'h45, 16'h0000);
        rd_chk(7'h40, 16'h0000);
        rd_chk(7'h41, 16'h0001);
        rd_chk(7'h42, 16'h0041);
        rd_chk(7'h43, 16'h0042);
        rd_chk(7'h44, 16'h0043);
        rd_chk(7'h45, 16'h0001);
        rd_chk(7'h46, 16'h2345);
        rd_chk(7'h47, 16'h0000);
        rd_chk(7'h48, 16'h0100);
        rd_chk(7'h0e, 16'h0041);
        rd_chk(7'h04, 16'h0001);
        $display("test good_frame done");
        fork
            begin
                tx.send_char(7'h02, 1'b0);
                tx.send_char(7'h41, 1'b1);
            end
            wait_frame();
        join
        chk1("frame_err", 1'b1, bad);
        rd_chk(7'h28, 16'h0001);
        rd_chk(7'h04, 16'h0000);
        rd_chk(7'h40, 16'h0000);
        rd_chk(7'h45, 16'h0001);
        rd_chk(7'h41, 16'h0001);
        $display("test parity_abort done");
        conclude();
    end
endmodule
